/* logic/cbfe_consts.svh */
// Register offsets, field positions, reset values and bus constants of the flag bank
`ifndef CBFE_CONSTS_SVH
`define CBFE_CONSTS_SVH

`define CBFE_OFF_PROT 8'h21
`define CBFE_OFF_FLAGA 8'h22
`define CBFE_OFF_FLAGB 8'h23

`define CBFE_RST_PROT 8'h00
`define CBFE_RST_FLAGA 8'h00
`define CBFE_RST_FLAGB 8'h00
`define CBFE_RST_PTR 8'h00

`define CBFE_B_SYS_SHORT 7
`define CBFE_B_SYS_OV 6
`define CBFE_B_OUT_OV 5
`define CBFE_B_OUT_UV 4
`define CBFE_B_OVERHEAT 2

`define CBFE_B_CUR_LIM 7
`define CBFE_B_VOLT_LIM 6
`define CBFE_B_WDOG 5
`define CBFE_B_WEAK 4
`define CBFE_B_PGOOD 3
`define CBFE_B_AC2 2
`define CBFE_B_AC1 1
`define CBFE_B_BUS 0

`define CBFE_B_CHG 7
`define CBFE_B_OPT 6
`define CBFE_B_BUSTYPE 4
`define CBFE_B_DIE_TEMP_REGULATION 2
`define CBFE_B_BATT 1
`define CBFE_B_DETECT 0

`define CBFE_DEV_ADDR 7'h42
`define CBFE_BITS_PER_BYTE 4'h8
`define CBFE_LAST_TX_BIT 4'h7

`endif

/* logic/cbfe_pkg.sv */
// Types shared by the charger flag bank
package cbfe_pkg;
	typedef struct packed {
		logic sys_rail_short_state;
		logic sys_rail_overvoltage_state;
		logic source_out_overvoltage_state;
		logic source_out_undervoltage_state;
		logic die_overheat_shutdown_state;
	} cbfe_prot_s;

	typedef struct packed {
		logic input_current_regulation;
		logic source_out_current_regulation;
		logic input_voltage_regulation;
		logic source_out_voltage_regulation;
		logic host_watchdog_expiry;
		logic weak_source;
		logic power_good_state;
		logic second_ac_input_present;
		logic first_ac_input_present;
		logic input_bus_present;
		logic [2:0] charge_state;
		logic [1:0] input_current_optimizer_state;
		logic [3:0] input_bus_type;
		logic die_temp_regulation;
		logic battery_present;
		logic [1:0] source_detection_state;
	} cbfe_src_s;

	typedef enum logic [7:0] {
		S_IDLE = 8'h01,
		S_ADDR = 8'h02,
		S_AACK = 8'h04,
		S_PTR = 8'h08,
		S_WACK = 8'h10,
		S_WDATA = 8'h20,
		S_RD = 8'h40,
		S_MACK = 8'h80
	} cbfe_state_e;
endpackage

/* logic/cbfe_flag_latch.sv */
// Eight sticky event flags, cleared by a read, set winning over clear
module cbfe_flag_latch
(
	input wire logic clk, // Device clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic [7:0] set_i, // One-cycle set requests
	input wire logic clr_i, // Clear all flags
	output logic [7:0] flags_o // Latched flags
);
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			flags_o <= 8'h00;
		else
			flags_o <= (flags_o & ~{8{clr_i}}) | set_i;
	end
endmodule

/* logic/cbfe_bus_cond.sv */
// Serial bus line sampler: clock edges, start and stop conditions
module cbfe_bus_cond
(
	input wire logic clk, // Device clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic scl, // Serial clock level
	input wire logic sda, // Serial data level
	output logic scl_rise, // Serial clock rose
	output logic scl_fall, // Serial clock fell
	output logic start, // Data fell while clock high
	output logic stop // Data rose while clock high
);
	logic scl_r;
	logic sda_r;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_r <= 1'b1;
			sda_r <= 1'b1;
		end
		else
		begin
			scl_r <= scl;
			sda_r <= sda;
		end
	end

	assign scl_rise = scl & ~scl_r;
	assign scl_fall = ~scl & scl_r;
	assign start = scl & scl_r & sda_r & ~sda;
	assign stop = scl & scl_r & ~sda_r & sda;
endmodule

/* logic/cbfe_flag_bank.sv */
// Charger protection status and event flag registers behind a serial target port
//
// Notes on behaviour
// - Status bit 7: system rail short
// - Status bit 6: system rail overvoltage
// - Status bit 5: source output overvoltage
// - Status bit 4: source output undervoltage
// - Status bit 2: overheat shutdown; 3,1,0 zero
// - Flag A7 on current regulation rising edge
// - Flag A6 on voltage regulation rising edge
// - Flag A5 on watchdog expiry rising edge
// - Flag A4 on weak source rising edge
// - Flag A3 on any power good change
// - Flag A2 on second input presence change
// - Flag A1 on first input presence change
// - Flag A0 on bus presence change
// - Flag B7 on charging state change
// - Flag B6 on optimizer change; 5,3 reserved
// - Flag B4 on bus source type change
// - Flag B2 on thermal regulation rising
// - Flag B1 on battery presence change
// - Flag B0 on source detection change
`include "cbfe_consts.svh"
module cbfe_flag_bank
(
	input wire logic CLK, // Device clock, 40 MHz
	input wire logic RESETN, // Asynchronous reset, active low
	input wire cbfe_pkg::cbfe_prot_s PROT, // Live protection conditions
	input wire cbfe_pkg::cbfe_src_s SRC, // Event source levels
	input wire logic SCL, // Serial clock from host
	input wire logic SDA_I, // Serial data line level
	output logic SDA_O, // Serial data drive value
	output logic SDA_OE // Serial data drive enable
);
	import cbfe_pkg::*;

	function automatic logic rise(input logic cur, input logic prev);
		return cur & ~prev;
	endfunction

	cbfe_state_e state_r;
	cbfe_state_e state_nxt;
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	logic [7:0] shift_r;
	logic [7:0] shift_nxt;
	logic [7:0] tx_r;
	logic [7:0] tx_nxt;
	logic [7:0] ptr_r;
	logic [7:0] ptr_nxt;
	logic rw_r;
	logic rw_nxt;
	logic nack_r;
	logic nack_nxt;
	logic oe_r;
	logic oe_nxt;
	logic sda_o_r;
	logic rd_load;
	cbfe_src_s src_prev_r;

	wire logic scl_rise;
	wire logic scl_fall;
	wire logic start;
	wire logic stop;
	wire logic [7:0] set_a;
	wire logic [7:0] set_b;
	wire logic [7:0] flags_a;
	wire logic [7:0] flags_b;
	wire logic [7:0] prot_byte;
	wire logic [7:0] rd_data;
	wire logic clr_a;
	wire logic clr_b;
	wire logic byte_in;

	cbfe_bus_cond u_cond
	(
		.clk(CLK),
		.rst_n(RESETN),
		.scl(SCL),
		.sda(SDA_I),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start(start),
		.stop(stop)
	);

	// Live protection byte, read straight from the conditions
	assign prot_byte[`CBFE_B_SYS_SHORT] = PROT.sys_rail_short_state;
	assign prot_byte[`CBFE_B_SYS_OV] = PROT.sys_rail_overvoltage_state;
	assign prot_byte[`CBFE_B_OUT_OV] = PROT.source_out_overvoltage_state;
	assign prot_byte[`CBFE_B_OUT_UV] = PROT.source_out_undervoltage_state;
	assign prot_byte[`CBFE_B_OVERHEAT] = PROT.die_overheat_shutdown_state;
	assign prot_byte[3] = 1'b0;
	assign prot_byte[1:0] = 2'b00;

	// Event detection against last cycle's levels
	assign set_a[`CBFE_B_CUR_LIM] = rise(SRC.input_current_regulation
		| SRC.source_out_current_regulation, src_prev_r.input_current_regulation
		| src_prev_r.source_out_current_regulation);
	assign set_a[`CBFE_B_VOLT_LIM] = rise(SRC.input_voltage_regulation
		| SRC.source_out_voltage_regulation, src_prev_r.input_voltage_regulation
		| src_prev_r.source_out_voltage_regulation);
	assign set_a[`CBFE_B_WDOG] = rise(SRC.host_watchdog_expiry,
		src_prev_r.host_watchdog_expiry);
	assign set_a[`CBFE_B_WEAK] = rise(SRC.weak_source, src_prev_r.weak_source);
	assign set_a[`CBFE_B_PGOOD] = SRC.power_good_state ^ src_prev_r.power_good_state;
	assign set_a[`CBFE_B_AC2] = SRC.second_ac_input_present
		^ src_prev_r.second_ac_input_present;
	assign set_a[`CBFE_B_AC1] = SRC.first_ac_input_present
		^ src_prev_r.first_ac_input_present;
	assign set_a[`CBFE_B_BUS] = SRC.input_bus_present ^ src_prev_r.input_bus_present;

	assign set_b[`CBFE_B_CHG] = SRC.charge_state != src_prev_r.charge_state;
	assign set_b[`CBFE_B_OPT] = SRC.input_current_optimizer_state
		!= src_prev_r.input_current_optimizer_state;
	assign set_b[5] = 1'b0;
	assign set_b[`CBFE_B_BUSTYPE] = SRC.input_bus_type != src_prev_r.input_bus_type;
	assign set_b[3] = 1'b0;
	assign set_b[`CBFE_B_DIE_TEMP_REGULATION] = rise(SRC.die_temp_regulation,
		src_prev_r.die_temp_regulation);
	assign set_b[`CBFE_B_BATT] = SRC.battery_present ^ src_prev_r.battery_present;
	assign set_b[`CBFE_B_DETECT] = SRC.source_detection_state
		!= src_prev_r.source_detection_state;

	// A flag register is cleared when its byte is loaded for transmission
	assign clr_a = rd_load && (ptr_r == `CBFE_OFF_FLAGA);
	assign clr_b = rd_load && (ptr_r == `CBFE_OFF_FLAGB);

	cbfe_flag_latch u_flags_a
	(
		.clk(CLK),
		.rst_n(RESETN),
		.set_i(set_a),
		.clr_i(clr_a),
		.flags_o(flags_a)
	);

	cbfe_flag_latch u_flags_b
	(
		.clk(CLK),
		.rst_n(RESETN),
		.set_i(set_b),
		.clr_i(clr_b),
		.flags_o(flags_b)
	);

	assign rd_data = (ptr_r == `CBFE_OFF_PROT) ? prot_byte :
		(ptr_r == `CBFE_OFF_FLAGA) ? flags_a :
		(ptr_r == `CBFE_OFF_FLAGB) ? flags_b : 8'h00;

	assign byte_in = scl_fall && (cnt_r == `CBFE_BITS_PER_BYTE);

	// Serial target sequencing
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		shift_nxt = shift_r;
		tx_nxt = tx_r;
		ptr_nxt = ptr_r;
		rw_nxt = rw_r;
		nack_nxt = nack_r;
		oe_nxt = oe_r;
		rd_load = 1'b0;
		if (stop)
		begin
			state_nxt = S_IDLE;
			oe_nxt = 1'b0;
		end
		else if (start)
		begin
			state_nxt = S_ADDR;
			cnt_nxt = 4'h0;
			oe_nxt = 1'b0;
		end
		else
		begin
			case (state_r)
				S_ADDR, S_PTR, S_WDATA:
				begin
					if (scl_rise && (cnt_r != `CBFE_BITS_PER_BYTE))
					begin
						shift_nxt = {shift_r[6:0], SDA_I};
						cnt_nxt = cnt_r + 4'h1;
					end
					else if (byte_in && (state_r == S_ADDR))
					begin
						if (shift_r[7:1] == `CBFE_DEV_ADDR)
						begin
							oe_nxt = 1'b1;
							rw_nxt = shift_r[0];
							state_nxt = S_AACK;
						end
						else
							state_nxt = S_IDLE;
					end
					else if (byte_in)
					begin
						// Pointer and data bytes are acknowledged; only a pointer byte changes anything, loading ptr_r
						oe_nxt = 1'b1;
						state_nxt = S_WACK;
						if (state_r == S_PTR)
							ptr_nxt = shift_r;
					end
				end
				S_AACK, S_MACK:
				begin
					if (scl_rise && (state_r == S_MACK))
					begin
						nack_nxt = SDA_I;
						if (!SDA_I)
							ptr_nxt = ptr_r + 8'h01;
					end
					else if (scl_fall)
					begin
						if ((state_r == S_AACK) ? rw_r : !nack_r)
						begin
							rd_load = 1'b1;
							tx_nxt = rd_data;
							oe_nxt = ~rd_data[7];
							cnt_nxt = 4'h0;
							state_nxt = S_RD;
						end
						else
						begin
							oe_nxt = 1'b0;
							cnt_nxt = 4'h0;
							state_nxt = (state_r == S_AACK) ? S_PTR : S_IDLE;
						end
					end
				end
				S_WACK:
				begin
					if (scl_fall)
					begin
						oe_nxt = 1'b0;
						cnt_nxt = 4'h0;
						state_nxt = S_WDATA;
					end
				end
				S_RD:
				begin
					if (scl_fall)
					begin
						if (cnt_r == `CBFE_LAST_TX_BIT)
						begin
							oe_nxt = 1'b0;
							state_nxt = S_MACK;
						end
						else
						begin
							tx_nxt = {tx_r[6:0], 1'b0};
							oe_nxt = ~tx_r[6];
							cnt_nxt = cnt_r + 4'h1;
						end
					end
				end
				S_IDLE:
					oe_nxt = 1'b0;
				default:
				begin
					state_nxt = S_IDLE;
					oe_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			state_r <= S_IDLE;
			cnt_r <= 4'h0;
			shift_r <= 8'h00;
			tx_r <= 8'h00;
			ptr_r <= `CBFE_RST_PTR;
			rw_r <= 1'b0;
			nack_r <= 1'b1;
			oe_r <= 1'b0;
			sda_o_r <= 1'b0;
			src_prev_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			shift_r <= shift_nxt;
			tx_r <= tx_nxt;
			ptr_r <= ptr_nxt;
			rw_r <= rw_nxt;
			nack_r <= nack_nxt;
			oe_r <= oe_nxt;
			sda_o_r <= 1'b0;
			src_prev_r <= SRC;
		end
	end

	assign SDA_O = sda_o_r;
	assign SDA_OE = oe_r;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESETN);

	sequence s_cur_rise;
		$rose(SRC.input_current_regulation | SRC.source_out_current_regulation);
	endsequence

	sequence s_read_a;
		rd_load && (ptr_r == `CBFE_OFF_FLAGA) && (set_a == 8'h00);
	endsequence

	sequence s_read_prot;
		rd_load && (ptr_r == `CBFE_OFF_PROT);
	endsequence

	chk_cur_limit_flag: assert property (s_cur_rise |=> flags_a[7])
		else $error("current limit flag missed");
	chk_volt_limit_flag: assert property ($rose(SRC.input_voltage_regulation
		| SRC.source_out_voltage_regulation) |=> flags_a[6])
		else $error("voltage limit flag missed");
	chk_pgood_change: assert property ($changed(SRC.power_good_state)
		|=> flags_a[3])
		else $error("power good change flag missed");
	chk_charge_change: assert property ($changed(SRC.charge_state) |=> flags_b[7])
		else $error("charge change flag missed");
	chk_flag_read_clear: assert property (s_read_a |=> flags_a == 8'h00)
		else $error("flag register not cleared by read");
	chk_flag_sticky: assert property (flags_a[5] && !clr_a |=> flags_a[5])
		else $error("watchdog flag lost without read");
	chk_reserved_zero: assert property (flags_b[5] == 1'b0 && flags_b[3] == 1'b0)
		else $error("reserved flag bit set");
	chk_prot_live: assert property (s_read_prot |=> tx_r[7:4] == $past({
		PROT.sys_rail_short_state, PROT.sys_rail_overvoltage_state,
		PROT.source_out_overvoltage_state, PROT.source_out_undervoltage_state}))
		else $error("protection status byte wrong");
	chk_prot_reserved: assert property (s_read_prot |=> tx_r[3] == 1'b0
		&& tx_r[1:0] == 2'b00 && tx_r[2] == $past(PROT.die_overheat_shutdown_state))
		else $error("protection reserved or shutdown bit wrong");
	chk_stop_release: assert property (stop |=> !SDA_OE && state_r == S_IDLE)
		else $error("data line held after stop");
endmodule

/* testbench/cbfe_host.sv */
// Serial bus host model that reads and writes the flag bank registers
module cbfe_host
(
	input wire logic clk, // Device clock
	input wire logic sda, // Resolved data line
	output logic scl, // Serial clock drive
	output logic sda_low // Pulls data line low
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Data moves one clock after the fall, so it never races the clock edge
	task automatic put_bit(input logic v);
		tick(1);
		sda_low <= ~v;
		tick(3);
		scl <= 1'b1;
		tick(4);
		scl <= 1'b0;
	endtask

	task automatic get_bit(output logic v);
		tick(1);
		sda_low <= 1'b0;
		tick(3);
		scl <= 1'b1;
		tick(4);
		v = sda;
		scl <= 1'b0;
	endtask

	// Start when go is 1, stop when go is 0
	task automatic frame(input logic go);
		tick(1);
		sda_low <= ~go;
		tick(3);
		scl <= 1'b1;
		tick(4);
		sda_low <= go;
		tick(4);
		scl <= ~go;
	endtask

	task automatic send(input logic [7:0] d, inout logic ok);
		logic a;
		for (int i = 7; i >= 0; i--)
			put_bit(d[i]);
		get_bit(a);
		ok &= ~a;
	endtask

	task automatic recv(input logic last, output logic [7:0] d);
		logic a;
		for (int i = 7; i >= 0; i--)
		begin
			get_bit(a);
			d[i] = a;
		end
		put_bit(last);
	endtask

	task automatic read_pair(input logic [6:0] dev, input logic [7:0] ptr, output logic ok,
		output logic [7:0] a, output logic [7:0] b);
		ok = 1'b1;
		frame(1'b1);
		send({dev, 1'b0}, ok);
		send(ptr, ok);
		frame(1'b1);
		send({dev, 1'b1}, ok);
		recv(1'b0, a);
		recv(1'b1, b);
		frame(1'b0);
	endtask

	task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
		input logic [7:0] d, output logic ok);
		ok = 1'b1;
		frame(1'b1);
		send({dev, 1'b0}, ok);
		send(ptr, ok);
		send(d, ok);
		frame(1'b0);
	endtask
endmodule

/* testbench/cbfe_flag_bank_test.sv */
// Self-checking bench for the charger flag bank
`include "cbfe_consts.svh"
module cbfe_flag_bank_test;
	timeunit 1ns;
	timeprecision 1ps;
	import cbfe_pkg::*;

	logic clk;
	logic resetn;
	logic scl;
	logic sda_low;
	logic sda_o;
	logic sda_oe;
	logic sda_line;
	logic ok;
	logic [7:0] ra;
	logic [7:0] rb;
	cbfe_prot_s prot;
	cbfe_src_s src;
	cbfe_src_s s;
	int err_count;
	int compares;
	logic [7:0] pexp [5] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h04};

	// Open drain line with pull-up
	assign sda_line = ~((sda_oe & ~sda_o) | sda_low);

	cbfe_flag_bank cbfe_flag_bank_i
	(
		.CLK(clk),
		.RESETN(resetn),
		.PROT(prot),
		.SRC(src),
		.SCL(scl),
		.SDA_I(sda_line),
		.SDA_O(sda_o),
		.SDA_OE(sda_oe)
	);

	cbfe_host cbfe_host_i
	(
		.clk(clk),
		.sda(sda_line),
		.scl(scl),
		.sda_low(sda_low)
	);

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Two-byte read from ptr, acknowledges checked as well
	task automatic rd(input logic [7:0] ptr, input logic [7:0] ea, input logic [7:0] eb);
		cbfe_host_i.tick(3);
		cbfe_host_i.read_pair(`CBFE_DEV_ADDR, ptr, ok, ra, rb);
		check("ack", 8'h01, {7'h00, ok});
		check("first byte", ea, ra);
		check("second byte", eb, rb);
	endtask

	task automatic step(input logic [7:0] ea, input logic [7:0] eb);
		@(posedge clk);
		src <= s;
		rd(`CBFE_OFF_FLAGA, ea, eb);
	endtask

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		resetn = 1'b0;
		prot = '0;
		src = '0;
		s = '0;
		err_count = 0;
		compares = 0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		rd(`CBFE_OFF_PROT, `CBFE_RST_PROT, `CBFE_RST_FLAGA);
		rd(`CBFE_OFF_FLAGB, `CBFE_RST_FLAGB, 8'h00);
		rd(8'h30, 8'h00, 8'h00);
		for (int i = 0; i < 5; i++)
		begin
			prot <= 5'h10 >> i;
			rd(`CBFE_OFF_PROT, pexp[i], 8'h00);
		end
		prot <= 5'h1f;
		rd(`CBFE_OFF_PROT, 8'hf4, 8'h00);
		prot <= 5'h00;
		rd(`CBFE_OFF_PROT, 8'h00, 8'h00);
		// Write to a read-only place is acknowledged and has no effect
		cbfe_host_i.write_reg(`CBFE_DEV_ADDR, `CBFE_OFF_PROT, 8'hff, ok);
		check("write ack", 8'h01, {7'h00, ok});
		prot <= 5'h08;
		rd(`CBFE_OFF_PROT, 8'h40, 8'h00);
		cbfe_host_i.write_reg(7'h43, `CBFE_OFF_PROT, 8'h00, ok);
		check("foreign address ack", 8'h00, {7'h00, ok});
		prot <= 5'h00;
		s.input_current_regulation = 1'b1;
		step(8'h80, 8'h00);
		s.input_current_regulation = 1'b0;
		step(8'h00, 8'h00);
		s.source_out_current_regulation = 1'b1;
		step(8'h80, 8'h00);
		s.source_out_current_regulation = 1'b0;
		s.input_voltage_regulation = 1'b1;
		step(8'h40, 8'h00);
		s.input_voltage_regulation = 1'b0;
		step(8'h00, 8'h00);
		s.source_out_voltage_regulation = 1'b1;
		step(8'h40, 8'h00);
		// One-cycle expiry pulse must still be seen at the later read
		s.host_watchdog_expiry = 1'b1;
		@(posedge clk);
		src <= s;
		s.host_watchdog_expiry = 1'b0;
		step(8'h20, 8'h00);
		s.weak_source = 1'b1;
		step(8'h10, 8'h00);
		s.weak_source = 1'b0;
		s.power_good_state = 1'b1;
		step(8'h08, 8'h00);
		s.power_good_state = 1'b0;
		s.second_ac_input_present = 1'b1;
		step(8'h0c, 8'h00);
		s.second_ac_input_present = 1'b0;
		s.first_ac_input_present = 1'b1;
		step(8'h06, 8'h00);
		s.first_ac_input_present = 1'b0;
		s.input_bus_present = 1'b1;
		step(8'h03, 8'h00);
		s.input_bus_present = 1'b0;
		s.charge_state = 3'h5;
		step(8'h01, 8'h80);
		s.input_current_optimizer_state = 2'h2;
		step(8'h00, 8'h40);
		s.input_bus_type = 4'h9;
		step(8'h00, 8'h10);
		s.die_temp_regulation = 1'b1;
		step(8'h00, 8'h04);
		s.die_temp_regulation = 1'b0;
		s.battery_present = 1'b1;
		step(8'h00, 8'h02);
		s.battery_present = 1'b0;
		s.source_detection_state = 2'h1;
		step(8'h00, 8'h03);
		rd(`CBFE_OFF_FLAGB, 8'h00, 8'h00);
		tally_and_finish();
	end
endmodule
